// [common/ppd_pkg.sv]
// Purpose: Shared constants and carriers for the printer port DMA and pin select block.
// Assumes: 32-bit AHB-Lite register access, one word per register.
// Notes:   All register offsets here are byte addresses.
`default_nettype none
package ppd_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_PMC = 8'h00; // Power management control.
   localparam logic [ADDR_W-1:0] OFS_PCR = 8'h04; // Port configuration.
   localparam logic [ADDR_W-1:0] OFS_FCR = 8'h08; // Function control.
   localparam logic [ADDR_W-1:0] OFS_PTR = 8'h0c; // Power and test.
   localparam logic [ADDR_W-1:0] OFS_CTL = 8'h10; // Printer control.
   localparam logic [ADDR_W-1:0] OFS_STA = 8'h14; // Pin and DMA status, read only.
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int PMC_DMA_CFG = 3;  // Shared pin is DMA acknowledge, DMA configured.
   localparam int PMC_PP_POWER_DOWN_IN = 5;  // Power-down input quiets the printer pins.
   localparam int PCR_ECP_EN = 2;   // Extended-capabilities logic enabled.
   localparam int PCR_MODE_LSB = 5; // Three-bit port mode field.
   localparam logic [2:0] MODE_ECP = 3'h3;
   localparam int FCR_PNF_EN = 2;   // Printer-not-floppy selects the shared pins.
   localparam int PTR_CLK_STOP = 1; // Power-down stops internal clocks.
   localparam int PTR_OSC_STOP = 2; // Power-down stops the crystal oscillator.
   localparam int CTL_DMA_REQ = 0;  // Software posts a pending DMA transfer.
   localparam int CTL_SEL_PRN = 3;  // One drives the select output low, zero releases it.
   localparam int STA_CNT_LSB = 16; // DMA cycle count field.
   localparam logic [7:0] RST_REG8 = 8'h00;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   // ----------------------------------------------------------------
   // Pin carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic ack_strap_n;  // Shared DMA acknowledge or host mode strap pin.
      logic paper_out;
      logic printer_sel;
      logic printer_not_floppy_sel;          // Printer-not-floppy or drive-2 presence pin.
      logic pd3;          // Parallel data pin reused as raw read data.
      logic power_down;
      logic rd_n;
      logic wr_n;
   } ppd_pin_in_s;
   // Shared acknowledge and both strobes idle high, rest low. A mismatch here would
   // make the strobe edge detector see a false falling edge right after reset.
   localparam ppd_pin_in_s PIN_IDLE = 8'h83;
   typedef struct packed {
      logic dma_req;
      logic dma_req_oe;
      logic sel_prn;
      logic sel_prn_oe;
      logic host_strap;
      logic floppy_sel;
      logic drive2_present;
      logic raw_rd_extra;
      logic clk_stop;
      logic osc_stop;
      logic dma_cycle;
   } ppd_pin_out_s;
endpackage
`default_nettype wire

// [rtl/ppd_top.sv]
// Purpose: Printer port DMA handshake, shared pin selection and power-down pin control.
// Assumes: One 10 MHz clock hclk, asynchronous active-low reset hresetn.
// Notes:   Pins pass a three-flop filter; registers sit on an AHB-Lite slave.
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Pin filter
// ----------------------------------------------------------------
// Three flops per bit; a change counts once the second and third agree.
module ppd_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Raw pins and filtered result.
   input wire logic [W-1:0] raw,
   output logic [W-1:0] filt
);
   logic [W-1:0] s1_r, s2_r, s3_r, filt_nxt;
   // Only the second and third stages feed the filter, never the first.
   always_comb begin
      for (int i = 0; i < W; i++) begin
         filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt[i];
      end
   end
   // Register the chain.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_r <= RST;
         s2_r <= RST;
         s3_r <= RST;
         filt <= RST;
      end else begin
         s1_r <= raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt <= filt_nxt;
      end
   end
endmodule // ppd_sync

// Operation
// [R01] A low acknowledge from the host DMA controller grants the request and turns strobes into DMA cycles.
// [R02] The shared pin is the DMA acknowledge when power management bit 3 is 1 and the host strap when 0.
// [R03] With that bit 0 the acknowledge reads inactive, and with it 1 the strap reads as 1.
// [R04] The acknowledge is honoured only in ECP mode and ignored in every other mode.
// [R05] The DMA request output is driven high to ask for a printer transfer.
// [R06] The DMA request is released when ECP is disabled or no DMA is configured.
// [R07] The DMA request carries a meaningful level only in ECP mode.
// [R08] The printer drives paper-out high when out of paper and the block reports it.
// [R09] A connected printer holds printer-selected high so its presence can be seen.
// [R10] The select-printer output is driven low to select the printer.
// [R11] Writing 0 to the select control bit releases the select pin instead of driving it.
// [R12] With function control bit 2 at 1, printer-not-floppy picks printer (1) or floppy (0).
// [R13] With function control bit 2 at 0, printer-not-floppy is the drive-2 presence input.
// [R14] In shared-pin floppy mode a parallel data pin is an extra raw read data input.
// [R15] Power-down stops clocks and/or oscillator per power-test bits 1-2 and quiets enabled pins.
module ppd_top
   import ppd_pkg::*;
(
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Device pins.
   input wire ppd_pkg::ppd_pin_in_s pin_in,
   output ppd_pkg::ppd_pin_out_s pin_out
);
   import ppd_pkg::*;

   // ----------------------------------------------------------------
   // Pin filtering
   // ----------------------------------------------------------------
   ppd_pin_in_s pf;
   ppd_sync #(.W($bits(ppd_pin_in_s)), .RST(PIN_IDLE)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .raw(pin_in),
      .filt(pf)
   );

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0] pmc_r, pcr_r, fcr_r, ptr_r, ctl_r;
   logic [7:0] pmc_nxt, pcr_nxt, fcr_nxt, ptr_nxt, ctl_nxt;
   logic dph_wr_r, dph_wr_nxt;
   logic [ADDR_W-1:0] dph_addr_r, dph_addr_nxt;
   logic [31:0] hrdata_nxt;
   logic dma_pend_r, dma_pend_nxt;
   logic [7:0] dma_cnt_r, dma_cnt_nxt;
   logic addr_ph;
   logic [31:0] status_word;
   logic ecp_mode, dma_cfg, ack_live, dma_strobe;
   logic rd_q_r, wr_q_r;
   ppd_pin_out_s out_nxt;

   // Address phase is taken only with hready high, so the slave never misses one.
   assign addr_ph = hsel && htrans[1] && hready;
   assign ecp_mode = pcr_r[PCR_ECP_EN] &&
                     (pcr_r[PCR_MODE_LSB +: 3] == MODE_ECP);
   assign dma_cfg = pmc_r[PMC_DMA_CFG];
   // Acknowledge reads inactive unless configured, and counts only in ECP mode.
   assign ack_live = dma_cfg && !pf.ack_strap_n && ecp_mode;    // [R02] [R03] [R04]
   // A falling strobe edge while granted is one DMA transfer cycle.
   assign dma_strobe = ack_live &&
                       ((rd_q_r && !pf.rd_n) || (wr_q_r && !pf.wr_n)); // [R01]

   // Status word reports printer inputs, strap, routing and DMA state.
   assign status_word = {8'h00, dma_cnt_r, 5'h00, dma_pend_r, ecp_mode,
                         pin_out.dma_req, pf.power_down, pin_out.raw_rd_extra,
                         pin_out.drive2_present, pf.printer_not_floppy_sel, pin_out.host_strap,
                         !ack_live, pf.printer_sel, pf.paper_out}; // [R08] [R09]

   // ----------------------------------------------------------------
   // Bus and register next state
   // ----------------------------------------------------------------
   // Writes land in the data phase; reads are prepared at the address phase.
   always_comb begin
      pmc_nxt = pmc_r;
      pcr_nxt = pcr_r;
      fcr_nxt = fcr_r;
      ptr_nxt = ptr_r;
      ctl_nxt = ctl_r;
      dph_wr_nxt = addr_ph && hwrite;
      dph_addr_nxt = addr_ph ? haddr[ADDR_W-1:0] : dph_addr_r;
      hrdata_nxt = hrdata;
      if (dph_wr_r) begin
         case (dph_addr_r)
            OFS_PMC: pmc_nxt = hwdata[7:0];
            OFS_PCR: pcr_nxt = hwdata[7:0];
            OFS_FCR: fcr_nxt = hwdata[7:0];
            OFS_PTR: ptr_nxt = hwdata[7:0];
            OFS_CTL: ctl_nxt = hwdata[7:0];
            default: ctl_nxt = ctl_r;
         endcase
      end
      if (addr_ph && !hwrite) begin
         case (haddr[ADDR_W-1:0])
            OFS_PMC: hrdata_nxt = {24'h000000, pmc_r};
            OFS_PCR: hrdata_nxt = {24'h000000, pcr_r};
            OFS_FCR: hrdata_nxt = {24'h000000, fcr_r};
            OFS_PTR: hrdata_nxt = {24'h000000, ptr_r};
            OFS_CTL: hrdata_nxt = {24'h000000, ctl_r};
            OFS_STA: hrdata_nxt = status_word;
            default: hrdata_nxt = RD_ZERO;
         endcase
      end
   end

   // Register the bus group; the slave is always ready with an OKAY answer.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pmc_r <= RST_REG8;
         pcr_r <= RST_REG8;
         fcr_r <= RST_REG8;
         ptr_r <= RST_REG8;
         ctl_r <= RST_REG8;
         dph_wr_r <= 1'b0;
         dph_addr_r <= '0;
         hrdata <= RD_ZERO;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         pmc_r <= pmc_nxt;
         pcr_r <= pcr_nxt;
         fcr_r <= fcr_nxt;
         ptr_r <= ptr_nxt;
         ctl_r <= ctl_nxt;
         dph_wr_r <= dph_wr_nxt;
         dph_addr_r <= dph_addr_nxt;
         hrdata <= hrdata_nxt;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // DMA handshake and pin next state
   // ----------------------------------------------------------------
   // A software post sets the pending flag; a DMA cycle clears it. Set wins,
   // so a post landing on the same edge as a transfer is never lost.
   always_comb begin
      dma_pend_nxt = dma_pend_r;
      dma_cnt_nxt = dma_cnt_r;
      if (dma_strobe) begin
         dma_pend_nxt = 1'b0;                                       // [R01]
         dma_cnt_nxt = dma_cnt_r + 8'h01;
      end
      if (dph_wr_r && dph_addr_r == OFS_CTL && hwdata[CTL_DMA_REQ]) begin
         dma_pend_nxt = 1'b1;
      end
      out_nxt.dma_cycle = dma_strobe;                               // [R01] [R04]
      out_nxt.dma_req = dma_pend_r && ecp_mode;                     // [R05] [R07]
      // Released when ECP or DMA is off, outside ECP mode, or in quiet power-down.
      out_nxt.dma_req_oe = pcr_r[PCR_ECP_EN] && dma_cfg && ecp_mode &&
                           !(pf.power_down && pmc_r[PMC_PP_POWER_DOWN_IN]);  // [R06] [R07] [R15]
      out_nxt.sel_prn = 1'b0;                                       // [R10]
      out_nxt.sel_prn_oe = ctl_r[CTL_SEL_PRN] &&
                           !(pf.power_down && pmc_r[PMC_PP_POWER_DOWN_IN]);  // [R11] [R15]
      out_nxt.host_strap = dma_cfg ? 1'b1 : pf.ack_strap_n;         // [R02] [R03]
      out_nxt.floppy_sel = fcr_r[FCR_PNF_EN] && !pf.printer_not_floppy_sel;            // [R12]
      out_nxt.drive2_present = !fcr_r[FCR_PNF_EN] && pf.printer_not_floppy_sel;        // [R13]
      out_nxt.raw_rd_extra = out_nxt.floppy_sel && pf.pd3;          // [R14]
      out_nxt.clk_stop = pf.power_down && ptr_r[PTR_CLK_STOP];      // [R15]
      out_nxt.osc_stop = pf.power_down && ptr_r[PTR_OSC_STOP];      // [R15]
   end

   // Register the pin group so every output comes from a flop.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dma_pend_r <= 1'b0;
         dma_cnt_r <= RST_REG8;
         rd_q_r <= 1'b1;
         wr_q_r <= 1'b1;
         pin_out <= '0;
      end else begin
         dma_pend_r <= dma_pend_nxt;
         dma_cnt_r <= dma_cnt_nxt;
         rd_q_r <= pf.rd_n;
         wr_q_r <= pf.wr_n;
         pin_out <= out_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_sel_clear;
      dph_wr_r && dph_addr_r == OFS_CTL && !hwdata[CTL_SEL_PRN];
   endsequence
   sequence s_granted_fall;
      ack_live && rd_q_r && !pf.rd_n;
   endsequence

   a_req_release: assert property (@(posedge hclk) disable iff (!hresetn) // [R06]
      (!pcr_r[PCR_ECP_EN] || !dma_cfg) |=> !pin_out.dma_req_oe)
      else $error("DMA request driven while ECP or DMA is off.");
   a_strap_forced: assert property (@(posedge hclk) disable iff (!hresetn) // [R03]
      dma_cfg |=> pin_out.host_strap)
      else $error("Host strap not forced high with DMA configured.");
   a_ack_ignored: assert property (@(posedge hclk) disable iff (!hresetn) // [R04]
      !ecp_mode |=> !pin_out.dma_cycle)
      else $error("DMA cycle counted outside ECP mode.");
   a_grant_cycle: assert property (@(posedge hclk) disable iff (!hresetn) // [R01]
      s_granted_fall |=> pin_out.dma_cycle ##1 !dma_pend_r)
      else $error("Granted strobe did not make one DMA cycle.");
   a_req_level: assert property (@(posedge hclk) disable iff (!hresetn) // [R05]
      pin_out.dma_req |-> $past(dma_pend_r) && $past(ecp_mode))
      else $error("DMA request high without a pending transfer.");
   a_sel_release: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
      s_sel_clear |=> ##1 !pin_out.sel_prn_oe)
      else $error("Select pin still driven after its bit was cleared.");
   a_pnf_route: assert property (@(posedge hclk) disable iff (!hresetn) // [R12]
      (fcr_r[FCR_PNF_EN] && pf.printer_not_floppy_sel) |=> !pin_out.floppy_sel && !pin_out.raw_rd_extra)
      else $error("Floppy routing chosen while printer is selected.");
   a_drive2_route: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
      !fcr_r[FCR_PNF_EN] |=> pin_out.drive2_present == $past(pf.printer_not_floppy_sel))
      else $error("Drive-2 presence does not follow its pin.");
   a_clk_stop: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
      (pf.power_down && ptr_r[PTR_CLK_STOP]) |=> pin_out.clk_stop)
      else $error("Power-down did not stop the clocks.");
   a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp)
      else $error("Slave answered other than ready and OKAY.");
endmodule // ppd_top
`default_nettype wire

// [bench/ppd_partner.sv]
// Purpose: Host DMA controller and attached printer as seen at the block's pins.
// Assumes: Pins change just after a rising edge of hclk.
// Notes:   Grants only a driven request, unless the bench sets rogue on purpose.
`timescale 1ns/100ps
`default_nettype none
module ppd_partner
   import ppd_pkg::*;
(
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Request from the block.
   input wire logic dma_req,
   input wire logic dma_req_oe,
   // Bench controls: slow grant, unasked grant, strap level, printer lines.
   input wire logic slow,
   input wire logic rogue,
   input wire logic strap,
   input wire logic [4:0] prn,
   // Pins and activity.
   output ppd_pkg::ppd_pin_in_s pin_in,
   output logic busy
);
   logic ack_n = 1'b1;
   logic rd_n = 1'b1;
   logic wr_n = 1'b1;
   logic use_wr = 1'b0;
   // The strap level stands on the shared pin whenever no grant is given.
   assign pin_in = {ack_n ? strap : 1'b0, prn, rd_n, wr_n};
   // One grant: acknowledge low, one strobe of four clocks, then release.
   // Read and write strobes alternate so both inputs see traffic.
   initial begin
      busy = 1'b0;
      forever begin
         @(posedge hclk);
         if (hresetn && ((dma_req && dma_req_oe) || rogue)) begin
            busy <= 1'b1;
            repeat (slow ? 12 : 2) @(posedge hclk);
            ack_n <= 1'b0;
            repeat (4) @(posedge hclk);
            if (use_wr) wr_n <= 1'b0;
            else rd_n <= 1'b0;
            repeat (4) @(posedge hclk);
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            repeat (4) @(posedge hclk);
            ack_n <= 1'b1;
            use_wr <= !use_wr;
            repeat (6) @(posedge hclk);
            busy <= 1'b0;
         end
      end
   end
endmodule // ppd_partner
`default_nettype wire

// [bench/printer_port_dma_and_pin_select_tb.sv]
// Purpose: Self-checking bench for the printer port DMA and pin select block.
// Assumes: One AHB-Lite slave, hready tied to hreadyout.
// Notes:   Pin checks wait out the three-flop input filter before sampling.
`timescale 1ns/100ps
`default_nettype none
module printer_port_dma_and_pin_select_tb;
   import ppd_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   ppd_pin_in_s pin_in;
   ppd_pin_out_s pin_out;
   logic slow = 1'b0;
   logic rogue = 1'b0;
   logic strap = 1'b1;
   logic [4:0] prn = 5'h00;
   logic busy;
   logic [7:0] reg_m [0:3] = '{default: 8'h00};
   logic [31:0] rd;
   int n_mismatch = 0;
   int compares = 0;
   int seed = 76;
   int cnt = 0;

   // 10 MHz bus clock.
   initial forever #50 hclk = ~hclk;

   ppd_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out));
   ppd_partner u_far (.hclk(hclk), .hresetn(hresetn), .dma_req(pin_out.dma_req),
      .dma_req_oe(pin_out.dma_req_oe), .slow(slow), .rogue(rogue), .strap(strap), .prn(prn),
      .pin_in(pin_in), .busy(busy));

   // ----------------------------------------------------------------
   // Model and helpers
   // ----------------------------------------------------------------
   // Expected low status byte from the modelled registers and pin levels.
   function automatic logic [7:0] exp_lo();
      logic m3;
      logic f2;
      logic ecp;
      m3 = reg_m[0][3];
      f2 = reg_m[2][2];
      // The acknowledge only counts when configured and in ECP mode.
      ecp = reg_m[1][2] && (reg_m[1][7:5] == MODE_ECP);
      return {prn[0], f2 & !prn[2] & prn[1], !f2 & prn[2], prn[2], m3 | strap,
              !(m3 & ecp & !strap), prn[3], prn[4]};
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One single word transfer; the answer is awaited, never assumed.
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
      check("bus_resp", {hreadyout, hresp}, 2'h2);
   endtask

   task automatic wait_busy(input logic lvl);
      int k;
      k = 0;
      while (busy !== lvl && k < 200) begin
         @(posedge hclk);
         k++;
      end
      check("partner_busy", busy, lvl);
   endtask

   task automatic settle();
      repeat (8) @(posedge hclk);
   endtask

   task automatic final_report();
      if (n_mismatch == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // A hang ends the run as a failure.
   initial begin
      repeat (20000) @(posedge hclk);
      n_mismatch++;
      final_report();
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] v;
      logic [7:0] e;
      logic [2:0] cfg;
      logic eo;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      settle();
      // Reset values, then an unmapped word.
      for (int i = 0; i < 7; i++) begin
         bus(8'(4 * i), 1'b0, 32'h0, rd);
         check("reset_read", rd & 32'h00ff_00ff, (i == 5) ? {24'h0, exp_lo()} : 32'h0);
      end
      // Random words; only the low byte is kept.
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         reg_m[i] = v[7:0];
         bus(8'(4 * i), 1'b1, v, rd);
         bus(8'(4 * i), 1'b0, 32'h0, rd);
         check("reg_rw", rd, {24'h0, v[7:0]});
      end
      bus(8'h18, 1'b1, 32'hffff_ffff, rd);
      bus(8'h18, 1'b0, 32'h0, rd);
      check("unmapped", rd, 32'h0);
      // Every DMA configuration; refused ones get an unasked grant.
      for (int i = 0; i < 10; i++) begin
         cfg = (i < 8) ? 3'(i) : 3'h7;
         eo = (cfg == 3'h7);
         v = $random(seed);
         slow <= (i == 9);
         reg_m[0] = {4'h0, cfg[0], 3'h0};
         reg_m[1] = {cfg[2] ? MODE_ECP : {1'b1, v[1:0]}, 2'h0, cfg[1], 2'h0};
         bus(OFS_PMC, 1'b1, {24'h0, reg_m[0]}, rd);
         bus(OFS_PCR, 1'b1, {24'h0, reg_m[1]}, rd);
         bus(OFS_CTL, 1'b1, 32'h1, rd);
         if (eo) begin
            wait_busy(1'b1);
            check("dma_req", {pin_out.dma_req, pin_out.dma_req_oe}, 2'h3);
            wait_busy(1'b0);
            cnt++;
         end else begin
            settle();
            check("dma_req_oe", pin_out.dma_req_oe, 1'b0);
            rogue <= 1'b1;
            wait_busy(1'b1);
            rogue <= 1'b0;
            wait_busy(1'b0);
         end
         settle();
         bus(OFS_STA, 1'b0, 32'h0, rd);
         check("dma_count", rd[23:16], cnt[7:0]);
         check("dma_pending", {rd[10], pin_out.dma_req & eo}, {!eo, 1'b0});
      end
      // Random pin levels against the shared pin selection.
      reg_m[1] = 8'h00;
      bus(OFS_PCR, 1'b1, 32'h0, rd);
      for (int i = 0; i < 12; i++) begin
         v = $random(seed);
         prn <= v[4:0];
         strap <= v[5];
         reg_m[0] = {4'h0, v[6], 3'h0};
         reg_m[2] = {5'h00, v[7], 2'h0};
         reg_m[3] = {5'h00, v[9:8], 1'b0};
         bus(OFS_PMC, 1'b1, {24'h0, reg_m[0]}, rd);
         bus(OFS_FCR, 1'b1, {24'h0, reg_m[2]}, rd);
         bus(OFS_PTR, 1'b1, {24'h0, reg_m[3]}, rd);
         settle();
         e = exp_lo();
         bus(OFS_STA, 1'b0, 32'h0, rd);
         check("status_pins", rd[7:0], e);
         check("shared_pins", {pin_out.host_strap, pin_out.floppy_sel, pin_out.drive2_present,
               pin_out.raw_rd_extra}, {e[3], reg_m[2][2] & !prn[2], e[5], e[6]});
         check("power_down", {pin_out.clk_stop, pin_out.osc_stop},
               {prn[0] & reg_m[3][1], prn[0] & reg_m[3][2]});
      end
      // Select output driven low, then released.
      for (int i = 1; i >= 0; i--) begin
         bus(OFS_CTL, 1'b1, {28'h0, i[0], 3'h0}, rd);
         settle();
         check("select_out", {pin_out.sel_prn_oe, pin_out.sel_prn}, {i[0], 1'b0});
      end
      final_report();
   end
endmodule // printer_port_dma_and_pin_select_tb
`default_nettype wire
